// *** logic/pit_pkg.sv ***
// Constants shared by the periodic interval timer files
package pit_pkg;

  // Register indices and their byte addresses on the bus
  localparam int          IDX_COUNTER  = 8;
  localparam int          IDX_RELOAD   = 9;
  localparam logic [31:0] ADDR_COUNTER = 32'(IDX_COUNTER * 4);
  localparam logic [31:0] ADDR_RELOAD  = 32'(IDX_RELOAD * 4);

  // Field layout
  localparam int COUNT_W     = 24;
  localparam int ENABLE_BIT  = 24;
  localparam int FLAG_BIT    = 25;
  localparam int MISSED_BIT  = 26;

  // Reset values
  localparam logic [23:0] RESET_COUNT  = 24'hffffff;
  localparam logic [23:0] RESET_RELOAD = 24'hffffff;
  localparam logic        RESET_FLAG   = 1'b0;
  localparam logic        RESET_MISSED = 1'b0;
  localparam logic        RESET_ENABLE = 1'b0;

  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
  localparam int          HPROT_PRIV    = 1;
  localparam logic [31:0] READ_ZERO     = 32'h00000000;

  // Timing: wait states inserted in each read data phase
  localparam int          RD_WAIT_CYCLES = 1;

  // Data phase states
  typedef enum logic [3:0] {
    DP_IDLE   = 4'h1,
    DP_WRITE  = 4'h2,
    DP_RDWAIT = 4'h4,
    DP_RDOUT  = 4'h8
  } pit_dphase_t;

  // Register selection carried into the data phase
  typedef enum logic [2:0] {
    SEL_NONE    = 3'h1,
    SEL_COUNTER = 3'h2,
    SEL_RELOAD  = 3'h4
  } pit_sel_t;

endpackage : pit_pkg

// *** logic/pit_down_counter.sv ***
// 24-bit down-counter with reload at zero and software load
`timescale 1ns/1ns
module pit_down_counter (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        load_en,
  input  wire logic [23:0] load_value,
  input  wire logic [23:0] reload_value,
  output logic      [23:0] count_value,
  output logic             at_zero
);

  assign at_zero = (count_value == 24'h000000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value <= pit_pkg::RESET_COUNT;
    end else if (load_en) begin
      count_value <= load_value;
    end else if (at_zero) begin
      count_value <= reload_value;
    end else begin
      count_value <= count_value - 24'h000001;
    end
  end

endmodule : pit_down_counter

// *** logic/pit_timer.sv ***
// Periodic interval timer with AHB-Lite register access
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module pit_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        all_traps_disable,
  input  wire logic        counter_irq_mask,
  output logic             timer_irq
);

  pit_pkg::pit_dphase_t dp_state;
  pit_pkg::pit_dphase_t next_dp_state;
  pit_pkg::pit_sel_t    dp_sel;
  pit_pkg::pit_sel_t    next_sel;

  logic        addr_phase;
  logic        priv;
  logic        cnt_wr;
  logic        rl_wr;
  logic [23:0] count_value;
  logic        at_zero;
  logic [23:0] reload_value;
  logic        expiry_flag;
  logic        missed_expiry_flag;
  logic        expiry_irq_enable;
  logic [31:0] counter_word;
  logic [31:0] reload_word;
  logic [31:0] read_word;

  // Bus slave
  assign addr_phase = hsel && htrans[1] && hready;
  assign priv       = hprot[pit_pkg::HPROT_PRIV];
  assign hresp      = pit_pkg::HRESP_OKAY;
  // Reads take one wait state so a write just before is visible
  assign hreadyout  = (dp_state != pit_pkg::DP_RDWAIT);

  always_comb begin
    next_sel = pit_pkg::SEL_NONE;
    if (priv && haddr == pit_pkg::ADDR_COUNTER) begin
      next_sel = pit_pkg::SEL_COUNTER;
    end else if (priv && haddr == pit_pkg::ADDR_RELOAD) begin
      next_sel = pit_pkg::SEL_RELOAD;
    end
  end

  always_comb begin
    next_dp_state = pit_pkg::DP_IDLE;
    case (dp_state)
      pit_pkg::DP_RDWAIT: begin
        next_dp_state = pit_pkg::DP_RDOUT;
      end
      pit_pkg::DP_IDLE,
      pit_pkg::DP_WRITE,
      pit_pkg::DP_RDOUT: begin
        if (addr_phase && hwrite) begin
          next_dp_state = pit_pkg::DP_WRITE;
        end else if (addr_phase) begin
          next_dp_state = pit_pkg::DP_RDWAIT;
        end
      end
      default: begin
        next_dp_state = pit_pkg::DP_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_state <= pit_pkg::DP_IDLE;
    end else begin
      dp_state <= next_dp_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_sel <= pit_pkg::SEL_NONE;
    end else if (addr_phase) begin
      dp_sel <= next_sel;
    end
  end

  // Writes land at the end of the data phase
  assign cnt_wr = (dp_state == pit_pkg::DP_WRITE) && (dp_sel == pit_pkg::SEL_COUNTER);
  assign rl_wr  = (dp_state == pit_pkg::DP_WRITE) && (dp_sel == pit_pkg::SEL_RELOAD);

  assign counter_word = {8'h00, count_value};
  assign reload_word  = {5'h00, missed_expiry_flag, expiry_flag, expiry_irq_enable,
                         reload_value};

  always_comb begin
    read_word = pit_pkg::READ_ZERO;
    case (dp_sel)
      pit_pkg::SEL_COUNTER: begin
        read_word = counter_word;
      end
      pit_pkg::SEL_RELOAD: begin
        read_word = reload_word;
      end
      default: begin
        read_word = pit_pkg::READ_ZERO;
      end
    endcase
  end

  // Unmapped or user-mode reads return zero with OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= pit_pkg::READ_ZERO;
    end else if (dp_state == pit_pkg::DP_RDWAIT) begin
      hrdata <= read_word;
    end
  end

  // Counter
  // Count write takes effect next cycle
  pit_down_counter u_counter (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .load_en      (cnt_wr),
    .load_value   (hwdata[pit_pkg::COUNT_W-1:0]),
    .reload_value (reload_value),
    .count_value  (count_value),
    .at_zero      (at_zero)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_value      <= pit_pkg::RESET_RELOAD;
      expiry_irq_enable <= pit_pkg::RESET_ENABLE;
    end else if (rl_wr) begin
      reload_value      <= hwdata[pit_pkg::COUNT_W-1:0];
      expiry_irq_enable <= hwdata[pit_pkg::ENABLE_BIT];
    end
  end

  // Expiry sets flag; set beats a clearing write
  // Only a reload write clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      expiry_flag <= pit_pkg::RESET_FLAG;
    end else if (at_zero) begin
      expiry_flag <= 1'b1;
    end else if (rl_wr) begin
      expiry_flag <= hwdata[pit_pkg::FLAG_BIT];
    end
  end

  // Missed expiry when flag still set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      missed_expiry_flag <= pit_pkg::RESET_MISSED;
    end else if (at_zero && expiry_flag) begin
      missed_expiry_flag <= 1'b1;
    end else if (rl_wr) begin
      missed_expiry_flag <= hwdata[pit_pkg::MISSED_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= expiry_flag && expiry_irq_enable && !counter_irq_mask
                   && !all_traps_disable;
    end
  end

  // Checks
  sequence s_load28;
    cnt_wr && (hwdata[pit_pkg::COUNT_W-1:0] == 24'h00001c);
  endsequence

  sequence s_run28;
    (count_value == 24'h00001c) ##28 (count_value == 24'h000000);
  endsequence

  sequence s_expire;
    at_zero && !cnt_wr;
  endsequence

  property p_interval;
    @(posedge hclk) disable iff (!hresetn)
    s_load28 ##1 (!cnt_wr throughout s_run28) |=> expiry_flag;
  endproperty

  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
    s_expire |=> (count_value == $past(reload_value));
  endproperty

  a_count_decrement: assert property (@(posedge hclk) disable iff (!hresetn)
    (!at_zero && !cnt_wr) |=> (count_value == $past(count_value) - 24'h000001))
    else $error("count did not decrement by one");

  a_zero_reload: assert property (p_reload)
    else $error("count not reloaded at zero");

  a_flag_on_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    at_zero |=> expiry_flag)
    else $error("expiry flag not set at zero");

  a_interval_len: assert property (p_interval)
    else $error("loaded 28 did not expire on cycle 29");

  a_zero_held: assert property (@(posedge hclk) disable iff (!hresetn)
    (!expiry_flag && !rl_wr && !at_zero) |=> !expiry_flag)
    else $error("flag set without a zero cycle");

  a_missed_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (at_zero && expiry_flag) |=> missed_expiry_flag)
    else $error("missed expiry not flagged");

  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (expiry_flag && expiry_irq_enable && !counter_irq_mask && !all_traps_disable)
    |=> timer_irq)
    else $error("interrupt not raised");

  a_irq_suppress: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(all_traps_disable || counter_irq_mask || !expiry_irq_enable) |-> !timer_irq)
    else $error("interrupt raised while disabled");

  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (expiry_flag && !rl_wr) |=> expiry_flag)
    else $error("expiry flag cleared by itself");

  a_user_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && !priv) |=> (dp_sel == pit_pkg::SEL_NONE))
    else $error("user-mode access reached a register");

  a_reload_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (rl_wr && !cnt_wr && !at_zero) |=> (count_value == $past(count_value) - 24'h000001))
    else $error("reload write disturbed count");

  a_count_write: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_wr |=> (count_value == $past(hwdata[pit_pkg::COUNT_W-1:0])))
    else $error("count write not applied");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (dp_state == pit_pkg::DP_RDWAIT) |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  a_zero_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (count_value == 24'h000001 && !cnt_wr && !rl_wr && !expiry_flag)
    |=> (at_zero && !expiry_flag))
    else $error("count did not hold zero before the flag");

  a_missed_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    (!missed_expiry_flag && !rl_wr && !(at_zero && expiry_flag)) |=> !missed_expiry_flag)
    else $error("missed expiry set without cause");

  a_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_irq |-> $past(expiry_flag && expiry_irq_enable))
    else $error("interrupt without flag and enable");

  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (rl_wr && !at_zero && !hwdata[pit_pkg::FLAG_BIT]) |=> !expiry_flag)
    else $error("software clear of the flag lost");

  a_reload_store: assert property (@(posedge hclk) disable iff (!hresetn)
    rl_wr |=> (reload_value == $past(hwdata[pit_pkg::COUNT_W-1:0])))
    else $error("reload value not stored");

  a_mask_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    counter_irq_mask |=> !timer_irq)
    else $error("interrupt raised while masked");

  // Read data is captured one cycle early so it stands the whole last cycle
  a_read_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (dp_state == pit_pkg::DP_RDWAIT) |=> (hrdata == $past(read_word)))
    else $error("read data not taken from the register");

  // Writes never stall; only reads pay the wait state
  a_write_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    (dp_state == pit_pkg::DP_WRITE) |-> hreadyout)
    else $error("write data phase stalled");

endmodule : pit_timer

// *** test/pit_timer_bench.sv ***
// Self-checking bench for the periodic interval timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module pit_timer_bench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [3:0]  hprot;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        all_traps_disable;
  logic        counter_irq_mask;
  logic        timer_irq;
  logic        rd_dp;
  logic        irq_q;
  logic        t;
  logic        m;
  logic [31:0] ev;
  logic [31:0] rd_q[$];
  int          rise_q[$];
  int          fail_count;
  int          comparisons;
  int          cyc;
  int          seed;
  int          w_edge;
  int          r1;
  int          r2;

  pit_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hprot(hprot), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .all_traps_disable(all_traps_disable), .counter_irq_mask(counter_irq_mask),
    .timer_irq(timer_irq));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // The whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Watcher: read data and interrupt rise edges against the noted results
  always @(posedge hclk) begin
    irq_q <= timer_irq;
    if (timer_irq === 1'b1 && irq_q === 1'b0 && rise_q.size() > 0) begin
      ev = 32'(rise_q.pop_front());
      `CHK("irq rise cycle", ev, 32'(cyc))
    end
    if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
      ev = rd_q.pop_front();
      `CHK("read data", ev, hrdata)
      `CHK("read response", pit_pkg::HRESP_OKAY, hresp)
    end
    if (hreadyout === 1'b1)
      rd_dp <= hsel & htrans[1] & ~hwrite;
  end

  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] p);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= pit_pkg::HTRANS_NONSEQ;
    hprot <= p;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    w_edge = cyc;
  endtask : xfer

  task rd(input logic [31:0] a, input logic [31:0] e, input logic [3:0] p);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h00000000, p);
  endtask : rd

  task wait_q(input int n);
    while (rise_q.size() > n)
      @(posedge hclk);
  endtask : wait_q

  initial begin
    seed = 13571;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hprot = 4'h3;
    hwdata = 32'h00000000;
    all_traps_disable = 1'b0;
    counter_irq_mask = 1'b0;
    rd_dp = 1'b0;
    irq_q = 1'b0;
    cyc = 0;
    fail_count = 0;
    comparisons = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(pit_pkg::ADDR_RELOAD, 32'h00ffffff, 4'h3);
    rd(32'h00000000, 32'h00000000, 4'h3);
    xfer(1'b1, pit_pkg::ADDR_RELOAD, 32'h01000005, 4'h1);
    rd(pit_pkg::ADDR_RELOAD, 32'h00000000, 4'h1);
    rd(pit_pkg::ADDR_RELOAD, 32'h00ffffff, 4'h3);
    r1 = 40 + ($random(seed) & 31);
    r2 = 40 + ($random(seed) & 31);
    counter_irq_mask <= 1'b1;
    xfer(1'b1, pit_pkg::ADDR_COUNTER, 32'd28, 4'h3);
    rise_q.push_back(w_edge + 31);
    rise_q.push_back(w_edge + 32 + r1);
    rise_q.push_back(w_edge + 33 + r1 + r2);
    xfer(1'b1, pit_pkg::ADDR_RELOAD, 32'h01000000 | 32'(r1), 4'h3);
    counter_irq_mask <= 1'b0;
    wait_q(2);
    rd(pit_pkg::ADDR_RELOAD, 32'h03000000 | 32'(r1), 4'h3);
    // Handler clears flag, sets next interval
    xfer(1'b1, pit_pkg::ADDR_RELOAD, 32'h01000000 | 32'(r2), 4'h3);
    repeat (2) @(posedge hclk);
    `CHK("irq after clear", 1'b0, timer_irq)
    wait_q(1);
    rd(pit_pkg::ADDR_RELOAD, 32'h03000000 | 32'(r2), 4'h3);
    xfer(1'b1, pit_pkg::ADDR_RELOAD, 32'h01000000 | 32'(r2), 4'h3);
    wait_q(0);
    repeat (8) begin
      t = 1'($random(seed));
      m = 1'($random(seed));
      all_traps_disable <= t;
      counter_irq_mask <= m;
      repeat (2) @(posedge hclk);
      `CHK("masked irq", ~(t | m), timer_irq)
    end
    all_traps_disable <= 1'b0;
    counter_irq_mask <= 1'b0;
    xfer(1'b1, pit_pkg::ADDR_COUNTER, 32'd5, 4'h3);
    xfer(1'b1, pit_pkg::ADDR_RELOAD, 32'h00000003, 4'h3);
    repeat (20) @(posedge hclk);
    `CHK("irq disabled", 1'b0, timer_irq)
    rd(pit_pkg::ADDR_RELOAD, 32'h06000003, 4'h3);
    repeat (4) @(posedge hclk);
    end_of_test();
  end
endmodule : pit_timer_bench
